// *** common/startup_pkg.sv ***
// Shared constants and types for the startup sequencer with readback
package startup_pkg;
    // Register map (byte addresses on the plain register port)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_EVENTS = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_MASK = 4'hc;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Startup clock source select
    typedef enum logic [1:0] {
        SRC_CCLK = 2'h0,
        SRC_USER = 2'h1,
        SRC_JTAG = 2'h2
    } clk_src_t;

    // Readback security modes
    typedef enum logic [1:0] {
        SEC_OPEN = 2'h0,
        SEC_NO_READBACK = 2'h1,
        SEC_NO_READBACK_RECONFIG = 2'h2
    } security_t;

    // Event placement codes: 0..6 are slots, the rest are special
    localparam logic [3:0] EV_DONE = 4'h7;
    localparam logic [3:0] EV_KEEP = 4'h8;
    localparam logic [3:0] EV_NOWAIT = 4'h9;
    localparam logic [2:0] SLOT_LAST = 3'h6;
    localparam logic [2:0] SLOT_FIRST_SEL = 3'h2;

    // Event vector positions
    localparam int EVT_DONE = 0;
    localparam int EVT_OE = 1;
    localparam int EVT_GSR = 2;
    localparam int EVT_GWE = 3;
    localparam int NUM_EVT = 4;

    // Control register fields
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_PIPE_BIT = 2;
    localparam int CTRL_DRIVE_BIT = 3;
    localparam int CTRL_SEC_LSB = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Events register: four bits per event, done in the low nibble
    localparam int EV_FIELD_W = 4;
    localparam int EV_DLL_LSB = 16;
    localparam logic [31:0] EVENTS_RESET = 32'h0009_6654;

    // Status register fields
    localparam int ST_SLOT_LSB = 0;
    localparam int ST_REL_LSB = 4;
    localparam int ST_DLL_BIT = 8;
    localparam int ST_RB_ACTIVE_BIT = 9;
    localparam int ST_REFUSED_BIT = 10;
    localparam int ST_MET_BIT = 11;

    // Event settings travel together
    typedef struct packed {
        logic [3:0] dll;
        logic [3:0] gwe;
        logic [3:0] gsr;
        logic [3:0] oe;
        logic [3:0] done;
    } event_cfg_t;

    // Startup sequence phase
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_SEQ = 2'h1,
        PH_FINISHED = 2'h2
    } phase_t;
endpackage : startup_pkg

// *** core/startup_sequencer_readback.sv ***
// Startup sequencer, serial readback port and readback security
`timescale 1ns/1ps
// Function
// - Startup clock: config, user or test clock
// - User source advances on user clock
// - Test source advances on test clock
// - Done pipe waits on delayed done
// - Five events: done, outputs, reset, write, DLL
// - C0 before, C1-C6 config clock edges
// - U2-U6 are user edges after C1
// - J2-J6 are test edges after C1
// - Events placed in slots, done or keep
// - DLL release in C0-C6 or no-wait
// - Keep holds level seen at done
// - No-wait releases DLL at once
// - Option to actively drive done high
// - Trigger rising edge starts readback
// - Readback bits shift out on clock
// - Disable-readback mode refuses every readback
// - Strictest mode blocks readback and reconfiguration
// - Stream carries only memory element states
module startup_sequencer_readback #(
    parameter int RB_BITS = 32
) (
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [startup_pkg::ADDR_W-1:0] regAddr,
    input wire logic [startup_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [startup_pkg::DATA_W-1:0] regRdata,
    // Configuration side, same clock
    input wire logic configStart,
    input wire logic lengthCountMet,
    input wire logic [RB_BITS-1:0] stateIn,
    // Pins and foreign clocks
    input wire logic cclk,
    input wire logic userClk,
    input wire logic tck,
    input wire logic readbackTrigger,
    input wire logic donePinIn,
    output logic donePinOut,
    output logic donePinOe_n,
    output logic outputsEnabled,
    output logic gsrActive,
    output logic gweActive,
    output logic dllRelease,
    output logic readbackData,
    output logic reconfigAllowed
);
    localparam int CNT_W = $clog2(RB_BITS + 1);

    // Pin synchronisers, three flops each; edges compare the second and third
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] pinRaw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] sync3_q;
    assign pinRaw = {donePinIn, readbackTrigger, tck, userClk, cclk};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= pinRaw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    logic [NSYNC-1:0] rise;
    assign rise = sync2_q & ~sync3_q;
    logic cclkRise, userRise, tckRise, trigRise, doneSensed;
    assign cclkRise = rise[0];
    assign userRise = rise[1];
    assign tckRise = rise[2];
    assign trigRise = rise[3];
    assign doneSensed = sync2_q[4];

    // Registers
    logic [startup_pkg::DATA_W-1:0] ctrl_q;
    logic [startup_pkg::DATA_W-1:0] events_q;
    logic [RB_BITS-1:0] mask_q;
    logic refused_q;
    startup_pkg::event_cfg_t evCfg;
    startup_pkg::clk_src_t clkSrc;
    startup_pkg::security_t security;
    logic donePipe;
    logic driveDone;
    assign evCfg = startup_pkg::event_cfg_t'(events_q[startup_pkg::EV_DLL_LSB+3:0]);
    assign clkSrc = startup_pkg::clk_src_t'(ctrl_q[startup_pkg::CTRL_SRC_LSB +: 2]);
    assign security = startup_pkg::security_t'(ctrl_q[startup_pkg::CTRL_SEC_LSB +: 2]);
    assign donePipe = ctrl_q[startup_pkg::CTRL_PIPE_BIT];
    assign driveDone = ctrl_q[startup_pkg::CTRL_DRIVE_BIT];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= startup_pkg::CTRL_RESET;
            events_q <= startup_pkg::EVENTS_RESET;
            mask_q <= '1;
        end else if (regWr) begin
            if (regAddr == startup_pkg::ADDR_CTRL) begin
                ctrl_q <= regWdata;
            end
            if (regAddr == startup_pkg::ADDR_EVENTS) begin
                events_q <= regWdata;
            end
            if (regAddr == startup_pkg::ADDR_MASK) begin
                mask_q <= regWdata[RB_BITS-1:0];
            end
        end
    end

    // Sequencer state
    startup_pkg::phase_t phase_q;
    logic [2:0] slot_q;
    logic [2:0] selEdges_q;
    logic [startup_pkg::NUM_EVT-1:0] rel_q;
    logic [startup_pkg::NUM_EVT-1:0] keepVal_q;
    logic doneRose_q;
    logic doneDly_q;
    logic dllRel_q;
    logic restart;
    // Strictest mode ignores a new configuration cycle
    assign restart = configStart && (security != startup_pkg::SEC_NO_READBACK_RECONFIG);

    // Startup edge: config clock up to C1, then the chosen source
    logic selRise;
    always_comb begin
        case (clkSrc)
            startup_pkg::SRC_USER: selRise = userRise;
            startup_pkg::SRC_JTAG: selRise = tckRise;
            default: selRise = cclkRise;
        endcase
    end
    logic startEdge;
    assign startEdge = (slot_q == 3'h0) ? cclkRise : selRise;
    // Done seen by the sequencer, optionally one startup edge late
    logic doneGate;
    assign doneGate = donePipe ? doneDly_q : doneSensed;
    // Sequence may not pass the done slot until done is seen high
    logic holdForDone;
    assign holdForDone = rel_q[startup_pkg::EVT_DONE] && !doneGate;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= startup_pkg::PH_IDLE;
            slot_q <= 3'h0;
            selEdges_q <= 3'h0;
        end else if (restart) begin
            phase_q <= startup_pkg::PH_IDLE;
            slot_q <= 3'h0;
            selEdges_q <= 3'h0;
        end else begin
            case (phase_q)
                startup_pkg::PH_IDLE: begin
                    if (lengthCountMet) begin
                        phase_q <= startup_pkg::PH_SEQ;
                    end
                end
                startup_pkg::PH_SEQ: begin
                    if (startEdge && !(holdForDone && slot_q != 3'h0)) begin
                        if (slot_q == 3'h0 || clkSrc == startup_pkg::SRC_CCLK) begin
                            slot_q <= slot_q + 3'h1;
                        end else begin
                            // Only the second and later selected edges after C1 count
                            selEdges_q <= selEdges_q + 3'h1;
                            if (selEdges_q + 3'h1 >= startup_pkg::SLOT_FIRST_SEL) begin
                                slot_q <= selEdges_q + 3'h1;
                            end
                        end
                        if (slot_q == startup_pkg::SLOT_LAST - 3'h1 ||
                            (slot_q != 3'h0 && clkSrc != startup_pkg::SRC_CCLK &&
                             selEdges_q + 3'h1 == startup_pkg::SLOT_LAST)) begin
                            phase_q <= startup_pkg::PH_FINISHED;
                        end
                    end
                end
                startup_pkg::PH_FINISHED: begin
                    phase_q <= startup_pkg::PH_FINISHED;
                end
                default: phase_q <= startup_pkg::PH_IDLE;
            endcase
        end
    end

    // Pipelined copy of done, sampled on startup edges
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            doneDly_q <= 1'b0;
        end else if (restart) begin
            doneDly_q <= 1'b0;
        end else if (startEdge) begin
            doneDly_q <= doneSensed;
        end
    end

    // Slot reached test for a placement code
    function automatic logic slotHit(input logic [3:0] code, input logic [2:0] slot,
                                     input logic active);
        logic hit;
        hit = 1'b0;
        if (code <= {1'b0, startup_pkg::SLOT_LAST}) begin
            hit = active && ({1'b0, slot} >= code);
        end
        return hit;
    endfunction : slotHit
    logic seqActive;
    assign seqActive = (phase_q != startup_pkg::PH_IDLE);
    logic [startup_pkg::NUM_EVT-1:0][3:0] evCode;
    assign evCode[startup_pkg::EVT_DONE] = evCfg.done;
    assign evCode[startup_pkg::EVT_OE] = evCfg.oe;
    assign evCode[startup_pkg::EVT_GSR] = evCfg.gsr;
    assign evCode[startup_pkg::EVT_GWE] = evCfg.gwe;
    // Done has risen once the gated done is high after its own event
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            doneRose_q <= 1'b0;
        end else if (restart) begin
            doneRose_q <= 1'b0;
        end else if (rel_q[startup_pkg::EVT_DONE] && doneGate) begin
            doneRose_q <= 1'b1;
        end
    end
    genvar g;
    generate
        for (g = 0; g < startup_pkg::NUM_EVT; g++) begin : gEvent
            logic fire;
            always_comb begin
                if (evCode[g] == startup_pkg::EV_DONE && g != startup_pkg::EVT_DONE) begin
                    // Stale done level from the previous cycle must not count
                    fire = rel_q[startup_pkg::EVT_DONE] && doneGate;
                end else begin
                    fire = slotHit(evCode[g], slot_q, seqActive) && slot_q != 3'h0;
                end
            end
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    rel_q[g] <= 1'b0;
                    keepVal_q[g] <= 1'b0;
                end else if (restart) begin
                    rel_q[g] <= 1'b0;
                    keepVal_q[g] <= 1'b0;
                end else if (evCode[g] == startup_pkg::EV_KEEP && g != startup_pkg::EVT_DONE) begin
                    // Capture the level once, when done is first seen
                    if (rel_q[startup_pkg::EVT_DONE] && doneGate && !doneRose_q) begin
                        keepVal_q[g] <= rel_q[g];
                    end
                    rel_q[g] <= keepVal_q[g];
                end else if (fire) begin
                    rel_q[g] <= 1'b1;
                end
            end
        end
    endgenerate
    // DLL release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dllRel_q <= 1'b0;
        end else if (restart) begin
            dllRel_q <= 1'b0;
        end else if (evCfg.dll == startup_pkg::EV_NOWAIT) begin
            // Not aligned to any startup edge
            if (lengthCountMet || seqActive) begin
                dllRel_q <= 1'b1;
            end
        end else if (evCfg.dll == 4'h0) begin
            if (seqActive) begin
                dllRel_q <= 1'b1;
            end
        end else if (slotHit(evCfg.dll, slot_q, seqActive)) begin
            dllRel_q <= 1'b1;
        end
    end

    // Event outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            donePinOut <= 1'b0;
            donePinOe_n <= 1'b0;
            outputsEnabled <= 1'b0;
            gsrActive <= 1'b1;
            gweActive <= 1'b1;
            dllRelease <= 1'b0;
            reconfigAllowed <= 1'b1;
        end else begin
            // Released done either floats to the pull-up or is driven high
            donePinOut <= rel_q[startup_pkg::EVT_DONE];
            donePinOe_n <= rel_q[startup_pkg::EVT_DONE] && !driveDone;
            outputsEnabled <= rel_q[startup_pkg::EVT_OE];
            gsrActive <= !rel_q[startup_pkg::EVT_GSR];
            gweActive <= !rel_q[startup_pkg::EVT_GWE];
            dllRelease <= dllRel_q;
            reconfigAllowed <= (security != startup_pkg::SEC_NO_READBACK_RECONFIG);
        end
    end

    // Readback
    logic [RB_BITS-1:0] rbShift_q;
    logic [CNT_W-1:0] rbLeft_q;
    logic rbActive;
    logic rbAllowed;
    logic rbRequest;
    assign rbActive = (rbLeft_q != '0);
    assign rbAllowed = (security == startup_pkg::SEC_OPEN);
    assign rbRequest = trigRise && phase_q == startup_pkg::PH_FINISHED && !rbActive;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rbShift_q <= '0;
            rbLeft_q <= '0;
            readbackData <= 1'b0;
        end else if (rbRequest && rbAllowed) begin
            // Only memory element positions carry state, the rest read zero
            rbShift_q <= stateIn & mask_q;
            rbLeft_q <= CNT_W'(RB_BITS);
        end else if (rbActive && cclkRise) begin
            readbackData <= rbShift_q[0];
            rbShift_q <= {1'b0, rbShift_q[RB_BITS-1:1]};
            rbLeft_q <= rbLeft_q - CNT_W'(1);
        end
    end

    // Refused requests are sticky; a new refusal beats a clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            refused_q <= 1'b0;
        end else if (rbRequest && !rbAllowed) begin
            refused_q <= 1'b1;
        end else if (regWr && regAddr == startup_pkg::ADDR_STATUS &&
                     regWdata[startup_pkg::ST_REFUSED_BIT]) begin
            refused_q <= 1'b0;
        end
    end

    // Read data, one cycle after the strobe
    logic [startup_pkg::DATA_W-1:0] status;
    always_comb begin
        status = '0;
        status[startup_pkg::ST_SLOT_LSB +: 3] = slot_q;
        status[startup_pkg::ST_REL_LSB +: startup_pkg::NUM_EVT] = rel_q;
        status[startup_pkg::ST_DLL_BIT] = dllRel_q;
        status[startup_pkg::ST_RB_ACTIVE_BIT] = rbActive;
        status[startup_pkg::ST_REFUSED_BIT] = refused_q;
        status[startup_pkg::ST_MET_BIT] = seqActive;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= '0;
        end else if (regRd) begin
            case (regAddr)
                startup_pkg::ADDR_CTRL: regRdata <= ctrl_q;
                startup_pkg::ADDR_EVENTS: regRdata <= events_q;
                startup_pkg::ADDR_STATUS: regRdata <= status;
                startup_pkg::ADDR_MASK: regRdata <= startup_pkg::DATA_W'(mask_q);
                default: regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end
endmodule : startup_sequencer_readback

// *** bench/startup_seq_chk.sv ***
// Concurrent checks on the startup sequencer pins and readback stream
`timescale 1ns/1ps
module startup_seq_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic regWr,
    input wire logic configStart,
    input wire logic lengthCountMet,
    input wire logic cclk,
    input wire logic userClk,
    input wire logic tck,
    input wire logic readbackTrigger,
    input wire logic donePinIn,
    input wire logic donePinOut,
    input wire logic donePinOe_n,
    input wire logic outputsEnabled,
    input wire logic gsrActive,
    input wire logic gweActive,
    input wire logic dllRelease,
    input wire logic readbackData,
    input wire logic reconfigAllowed
);
    logic [5:0] pins;
    logic [5:0] pinsPrev_q;
    logic [3:0] actAge_q;
    logic [3:0] cfgAge_q;
    assign pins = {cclk, userClk, tck, readbackTrigger, donePinIn, lengthCountMet};
    // Cycles since any legal cause of a pin move; saturates so it never wraps
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinsPrev_q <= 6'h00;
            actAge_q <= 4'h0;
        end else begin
            pinsPrev_q <= pins;
            if (pins != pinsPrev_q || regWr || configStart) begin
                actAge_q <= 4'h0;
            end else if (actAge_q != 4'hf) begin
                actAge_q <= actAge_q + 4'h1;
            end
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfgAge_q <= 4'h0;
        end else if (configStart) begin
            cfgAge_q <= 4'h0;
        end else if (cfgAge_q != 4'hf) begin
            cfgAge_q <= cfgAge_q + 4'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_done_drive_low: assert property (!donePinOut |-> !donePinOe_n)
        else $error("done pin released early");
    a_oe_hold: assert property (outputsEnabled && !configStart &&
        !$past(configStart) |=> outputsEnabled)
        else $error("outputs enable lost");
    a_gsr_hold: assert property (!gsrActive && !configStart &&
        !$past(configStart) |=> !gsrActive)
        else $error("set/reset came back");
    a_dll_hold: assert property (dllRelease && !configStart &&
        !$past(configStart) |=> dllRelease)
        else $error("dll release lost");
    a_done_fall: assert property ($fell(donePinOut) |-> cfgAge_q < 4'h4)
        else $error("done fell without new cycle");
    a_clear_all: assert property (configStart && reconfigAllowed |->
        ##[1:4] (gsrActive && gweActive && !outputsEnabled))
        else $error("events not cleared");
    a_lock_reconf: assert property (configStart && !reconfigAllowed |=>
        $stable(outputsEnabled) [*3])
        else $error("reconfiguration not blocked");
    a_oe_cause: assert property ($changed(outputsEnabled) |-> actAge_q < 4'h8)
        else $error("outputs moved without a cause");
    a_rb_cause: assert property ($changed(readbackData) |-> actAge_q < 4'h8)
        else $error("readback bit moved without a clock");
    c_done: cover property ($rose(donePinOut));
    c_stream: cover property ($changed(readbackData));
    c_locked: cover property (configStart && !reconfigAllowed);
endmodule : startup_seq_chk
bind startup_sequencer_readback startup_seq_chk chk_u (.mclk, .rst_n, .regWr, .configStart,
    .lengthCountMet, .cclk, .userClk, .tck, .readbackTrigger, .donePinIn, .donePinOut,
    .donePinOe_n, .outputsEnabled, .gsrActive, .gweActive, .dllRelease, .readbackData,
    .reconfigAllowed);

// *** bench/cfg_side_model.sv ***
// Far side model: startup clocks, done pin pull-up, readback capture
`timescale 1ns/1ps
module cfg_side_model (
    input wire logic readbackData,
    input wire logic donePinOut,
    input wire logic donePinOe_n,
    output logic cclk,
    output logic userClk,
    output logic tck,
    output logic donePinIn,
    output logic [31:0] rbWord
);
    logic [2:0] clks = 3'h0;
    assign {tck, userClk, cclk} = clks;
    // Pull-up holds the pin high once the device lets go
    assign donePinIn = donePinOe_n ? 1'b1 : donePinOut;
    // Clocks stand low between frames; one full pulse per wanted bit
    task automatic pulse(input int n, input int sel);
        for (int i = 0; i < n; i++) begin
            #62.5;
            clks[sel] = 1'b1;
            #62.5;
            rbWord = {readbackData, rbWord[31:1]};
            clks[sel] = 1'b0;
        end
    endtask : pulse
endmodule : cfg_side_model

// *** bench/tb_top.sv ***
// Self-checking bench for the startup sequencer with readback
`timescale 1ns/1ps
module tb_top;
    logic mclk, rst_n, regWr, regRd, configStart, lengthCountMet, readbackTrigger;
    logic cclk, userClk, tck, donePinIn, donePinOut, donePinOe_n, outputsEnabled;
    logic gsrActive, gweActive, dllRelease, readbackData, reconfigAllowed;
    logic [3:0] regAddr;
    logic [31:0] regWdata, regRdata, stateIn, rbWord, rd, mask;
    int miscompares, checksDone, cycles, seed, oeSlot, dllSlot;

    startup_sequencer_readback #(.RB_BITS(32)) dut_u (.mclk, .rst_n, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .configStart, .lengthCountMet, .stateIn, .cclk,
        .userClk, .tck, .readbackTrigger, .donePinIn, .donePinOut, .donePinOe_n,
        .outputsEnabled, .gsrActive, .gweActive, .dllRelease, .readbackData,
        .reconfigAllowed);
    cfg_side_model pm (.readbackData, .donePinOut, .donePinOe_n, .cclk, .userClk, .tck,
        .donePinIn, .rbWord);

    task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wrReg
    task automatic rdReg(input logic [3:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        rd = regRdata;
        @(posedge mclk);
    endtask : rdReg
    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkVal
    task automatic print_verdict();
        if (miscompares == 0 && checksDone > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    function automatic logic [31:0] rbExpect(input logic [31:0] s, input logic [31:0] m);
        return s & m;
    endfunction : rbExpect

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        {regAddr, regWdata, regWr, regRd, stateIn} = '0;
        {configStart, lengthCountMet, readbackTrigger, rst_n} = '0;
        seed = 30458;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        rdReg(startup_pkg::ADDR_CTRL);
        chkVal(rd, 32'h0);
        rdReg(startup_pkg::ADDR_EVENTS);
        chkVal(rd, {12'h0, 4'h9, 4'h6, 4'h6, 4'h5, 4'h4});
        rdReg(startup_pkg::ADDR_MASK);
        chkVal(rd, 32'hffff_ffff);
        rdReg(4'h2);
        chkVal(rd, 32'h0);
        lengthCountMet <= 1'b1;
        repeat (4) @(posedge mclk);
        chkVal(dllRelease, 1'b1);
        for (int k = 1; k <= 6; k++) begin
            pm.pulse(1, 0);
            chkVal(donePinOut, k >= 4);
            chkVal(donePinOe_n, k >= 4);
            chkVal(outputsEnabled, k >= 5);
            chkVal(gsrActive, k < 6);
            chkVal(gweActive, k < 6);
        end
        // User pass drives done actively; test pass uses the pull-up and the done pipe,
        // whose late done costs one startup edge after the done slot
        for (int src = 1; src <= 2; src++) begin
            oeSlot = 2 + $unsigned($random(seed)) % 5;
            dllSlot = 2 + $unsigned($random(seed)) % 5;
            wrReg(startup_pkg::ADDR_CTRL, 32'(src) | (src == 1 ? 32'h8 : 32'h4));
            lengthCountMet <= 1'b0;
            wrReg(startup_pkg::ADDR_EVENTS, {12'h0, 4'(dllSlot), startup_pkg::EV_KEEP,
                startup_pkg::EV_DONE, 4'(oeSlot), 4'h1});
            configStart <= 1'b1;
            @(posedge mclk);
            configStart <= 1'b0;
            lengthCountMet <= 1'b1;
            repeat (4) @(posedge mclk);
            chkVal(dllRelease, 1'b0);
            pm.pulse(1, 0);
            chkVal(donePinOut, 1'b1);
            for (int j = 1; j <= 5 + src; j++) begin
                pm.pulse(1, src);
                chkVal(outputsEnabled, j - src + 1 >= oeSlot);
                chkVal(dllRelease, j - src + 1 >= dllSlot);
            end
            chkVal(gsrActive, 1'b0);
            chkVal(gweActive, 1'b1);
            chkVal(donePinOe_n, src == 2);
        end
        mask = $random(seed);
        wrReg(startup_pkg::ADDR_MASK, mask);
        stateIn <= $random(seed);
        readbackTrigger <= 1'b1;
        repeat (6) @(posedge mclk);
        pm.pulse(32, 0);
        chkVal(rbWord, rbExpect(stateIn, mask));
        readbackTrigger <= 1'b0;
        wrReg(startup_pkg::ADDR_CTRL, 32'h10);
        readbackTrigger <= 1'b1;
        repeat (6) @(posedge mclk);
        rdReg(startup_pkg::ADDR_STATUS);
        chkVal(rd[10], 1'b1);
        wrReg(startup_pkg::ADDR_STATUS, 32'h400);
        rdReg(startup_pkg::ADDR_STATUS);
        chkVal(rd[10], 1'b0);
        readbackTrigger <= 1'b0;
        wrReg(startup_pkg::ADDR_CTRL, 32'h20);
        readbackTrigger <= 1'b1;
        repeat (6) @(posedge mclk);
        chkVal(reconfigAllowed, 1'b0);
        rdReg(startup_pkg::ADDR_STATUS);
        chkVal(rd[10], 1'b1);
        configStart <= 1'b1;
        @(posedge mclk);
        configStart <= 1'b0;
        repeat (4) @(posedge mclk);
        chkVal(outputsEnabled, 1'b1);
        print_verdict();
    end
endmodule : tb_top
